// ---- logic/interp_period_config.v ----
// interpolation period object, backlash compensation and jerk settings
`include "interp_period_consts.vh"
module interp_period_config #(
    parameter FEATURE_LEVEL = 4'h4,
    parameter POS_W         = 32
) (
    input  wire             CLOCK_I,
    input  wire             SYS_RST_I,
    input  wire             CE_I,
    input  wire [3:0]       ADDR_I,
    input  wire [31:0]      WDATA_I,
    input  wire             WR_I,
    input  wire             RD_I,
    output reg  [31:0]      RDATA_O,
    input  wire [2:0]       CYCLE_SEL_I,
    input  wire             CYCLE_LOAD_I,
    input  wire [POS_W-1:0] RAW_POS_I,
    input  wire             DIR_CHANGE_I,
    output reg  [POS_W-1:0] FEEDBACK_POS_O,
    output reg              MT_CLEAR_O,
    output reg              LASH_ACTIVE_O,
    output reg  [7:0]       PERIOD_MANT_O,
    output reg  [7:0]       PERIOD_EXP_O
);
    // cycle code, load strobe and direction arrive from outside this clock
    wire [2:0] cycle_s;
    wire       load_s;
    wire       dir_s;
    interp_sync3 #(.W(5)) u_sync (
        .clk_i (CLOCK_I),
        .rst_i (SYS_RST_I),
        .ce_i  (CE_I),
        .d_i   ({CYCLE_SEL_I, CYCLE_LOAD_I, DIR_CHANGE_I}),
        .q_o   ({cycle_s, load_s, dir_s})
    );

    reg [7:0]  mant_q;
    reg [7:0]  exp_q;
    reg [2:0]  cyc_q;
    reg        load_prev_q;
    reg [7:0]  lash_sel_q;
    reg [15:0] lash_amt_q;
    reg [15:0] lash_tc_q;
    reg [3:0]  ctrl_q;
    reg [7:0]  prof_kind_q;
    reg [31:0] jerk1_q;
    reg [31:0] jerk2_q;
    reg        jerk_use_q;
    reg        jerk_order_ok_q;
    reg [15:0] lash_cnt_q;
    reg        lash_trans_q;
    reg        mt_refused_q;
    reg [7:0]  tab_mant;
    reg [7:0]  tab_exp;
    reg [31:0] rd_d;

    // fixed cycle-to-period table; all eight codes are covered
    always @* begin
        case (cyc_q)
            `CYC_125US: begin
                tab_mant = `MANT_125US;
                tab_exp  = `EXP_125US;
            end
            `CYC_250US: begin
                tab_mant = `MANT_250US;
                tab_exp  = `EXP_250US;
            end
            `CYC_500US: begin
                tab_mant = `MANT_500US;
                tab_exp  = `EXP_500US;
            end
            `CYC_1MS: begin
                tab_mant = `MANT_1MS;
                tab_exp  = `EXP_MS;
            end
            `CYC_2MS: begin
                tab_mant = `MANT_2MS;
                tab_exp  = `EXP_MS;
            end
            `CYC_4MS: begin
                tab_mant = `MANT_4MS;
                tab_exp  = `EXP_MS;
            end
            `CYC_8MS: begin
                tab_mant = `MANT_8MS;
                tab_exp  = `EXP_MS;
            end
            default: begin
                tab_mant = `MANT_10MS;
                tab_exp  = `EXP_10MS;
            end
        endcase
    end

    // mode decode
    wire mt_allowed = (FEATURE_LEVEL >= `MT_CLEAR_MIN_LEVEL)
                      && ctrl_q[`CTRL_FULL_CLOSED] && ctrl_q[`CTRL_ROTARY];
    // a clear is judged on the mode bits written with it, not the old ones
    wire mt_ok_wr   = (FEATURE_LEVEL >= `MT_CLEAR_MIN_LEVEL)
                      && WDATA_I[`CTRL_FULL_CLOSED] && WDATA_I[`CTRL_ROTARY];
    wire lash_on    = ctrl_q[`CTRL_POS_MODE] && (lash_sel_q != 8'h00);
    wire wr_ctrl    = WR_I && (ADDR_I == `A_CONTROL);
    wire [POS_W-1:0] lash_ext = {{(POS_W-16){lash_amt_q[15]}}, lash_amt_q};
    // carry out of the sum is dropped: the position wraps like the raw count
    wire [POS_W-1:0] fb_sum   = RAW_POS_I + lash_ext;

    // load strobe edges after synchronisation
    wire load_rise  = load_s && !load_prev_q;
    wire load_fall  = load_prev_q && !load_s;

    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            mant_q          <= `MANT_125US;
            exp_q           <= `EXP_125US;
            cyc_q           <= `CYC_125US;
            load_prev_q     <= 1'b0;
            lash_sel_q      <= 8'h00;
            lash_amt_q      <= 16'h0000;
            lash_tc_q       <= 16'h0000;
            ctrl_q          <= 4'h0;
            prof_kind_q     <= 8'h00;
            jerk1_q         <= 32'h00000000;
            jerk2_q         <= 32'h00000000;
            jerk_use_q      <= 1'b0;
            jerk_order_ok_q <= 1'b0;
            lash_cnt_q      <= 16'h0000;
            lash_trans_q    <= 1'b0;
            mt_refused_q    <= 1'b0;
            MT_CLEAR_O      <= 1'b0;
            RDATA_O         <= 32'h00000000;
        end else if (CE_I) begin
            load_prev_q <= load_s;
            MT_CLEAR_O  <= 1'b0;
            // new cycle latched on load rising edge, table applied on its falling edge
            if (load_rise) begin
                cyc_q <= cycle_s;
            end
            if (load_fall) begin
                mant_q <= tab_mant;
                exp_q  <= tab_exp;
            end
            if (WR_I) begin
                case (ADDR_I)
                    `A_MANTISSA:     mant_q      <= WDATA_I[7:0];
                    `A_EXPONENT:     exp_q       <= WDATA_I[7:0];
                    `A_CYCLE_SEL:    cyc_q       <= WDATA_I[2:0];
                    `A_LASH_SELECT:  lash_sel_q  <= WDATA_I[7:0];
                    `A_LASH_AMOUNT:  lash_amt_q  <= WDATA_I[15:0];
                    `A_LASH_TCONST:  lash_tc_q   <= WDATA_I[15:0];
                    `A_CONTROL:      ctrl_q      <= {WDATA_I[3:1], 1'b0};
                    `A_PROFILE_KIND: prof_kind_q <= WDATA_I[7:0];
                    `A_JERK1:        jerk1_q     <= WDATA_I;
                    `A_JERK2:        jerk2_q     <= WDATA_I;
                    `A_JERK_USE: begin
                        jerk_use_q      <= WDATA_I[0];
                        // zero profile and jerks before enabling use
                        jerk_order_ok_q <= (prof_kind_q == 8'h00) && (jerk1_q == 32'h0)
                                           && (jerk2_q == 32'h0);
                    end
                    // entry 0, status and feedback are read-only: writes drop
                    default: ;
                endcase
            end
            if (wr_ctrl && WDATA_I[`CTRL_MT_CLEAR_BIT]) begin
                MT_CLEAR_O   <= mt_ok_wr;
                mt_refused_q <= !mt_ok_wr;
            end
            // transition lasts one cycle more than the time constant, in cycles
            // a new direction change restarts the countdown
            if (lash_on && dir_s) begin
                lash_trans_q <= 1'b1;
                lash_cnt_q   <= lash_tc_q;
            end else if (lash_trans_q) begin
                if (lash_cnt_q == 16'h0000) begin
                    lash_trans_q <= 1'b0;
                end else begin
                    lash_cnt_q <= lash_cnt_q - 16'h0001;
                end
            end
            if (!lash_on) begin
                lash_trans_q <= 1'b0;
            end
            // zero between reads so a stale word never looks like data
            RDATA_O <= (RD_I) ? rd_d : 32'h00000000;
        end
    end

    // read mux; unmapped entries read zero
    always @* begin
        case (ADDR_I)
            `A_HIGHEST:      rd_d = {24'h000000, `HIGHEST_ENTRY};
            `A_MANTISSA:     rd_d = {24'h000000, mant_q};
            `A_EXPONENT:     rd_d = {{24{exp_q[7]}}, exp_q};
            `A_CYCLE_SEL:    rd_d = {29'h00000000, cyc_q};
            `A_LASH_SELECT:  rd_d = {24'h000000, lash_sel_q};
            `A_LASH_AMOUNT:  rd_d = {16'h0000, lash_amt_q};
            `A_LASH_TCONST:  rd_d = {16'h0000, lash_tc_q};
            `A_CONTROL:      rd_d = {28'h0000000, ctrl_q};
            `A_STATUS:       rd_d = {28'h0000000, jerk_order_ok_q, mt_refused_q,
                                     lash_trans_q, mt_allowed};
            `A_FEEDBACK:     rd_d = FEEDBACK_POS_O;
            `A_PROFILE_KIND: rd_d = {24'h000000, prof_kind_q};
            `A_JERK1:        rd_d = jerk1_q;
            `A_JERK2:        rd_d = jerk2_q;
            `A_JERK_USE:     rd_d = {31'h00000000, jerk_use_q};
            default:         rd_d = 32'h00000000;
        endcase
    end

    // period = mantissa * 10^exponent seconds, exported raw
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            FEEDBACK_POS_O <= {POS_W{1'b0}};
            LASH_ACTIVE_O  <= 1'b0;
            PERIOD_MANT_O  <= `MANT_125US;
            PERIOD_EXP_O   <= `EXP_125US;
        end else if (CE_I) begin
            FEEDBACK_POS_O <= lash_trans_q ? fb_sum : RAW_POS_I;
            LASH_ACTIVE_O  <= lash_trans_q;
            PERIOD_MANT_O  <= mant_q;
            PERIOD_EXP_O   <= exp_q;
        end
    end
endmodule // interp_period_config

// ---- logic/interp_period_consts.vh ----
// constants for the interpolation period configuration block
// Summary of operation
// - the period value and index are loaded from the active communication cycle per the fixed cycle table.
// - entry 0 is a read-only 8-bit field that always reads 2.
// - multi-turn data may be cleared under full-closed control with a rotary scale, unless the feature level is 2 or lower.
// - in position control, backlash is compensated by selection, amount and time constant.
// - reported feedback includes the backlash correction only while in transition, and excludes it once complete.
`ifndef INTERP_PERIOD_CONSTS_VH
`define INTERP_PERIOD_CONSTS_VH
`define ADDR_W              4
`define A_HIGHEST           4'h0
`define A_MANTISSA          4'h1
`define A_EXPONENT          4'h2
`define A_CYCLE_SEL         4'h3
`define A_LASH_SELECT       4'h4
`define A_LASH_AMOUNT       4'h5
`define A_LASH_TCONST       4'h6
`define A_CONTROL           4'h7
`define A_STATUS            4'h8
`define A_FEEDBACK          4'h9
`define A_PROFILE_KIND      4'hA
`define A_JERK1             4'hB
`define A_JERK2             4'hC
`define A_JERK_USE          4'hD
`define HIGHEST_ENTRY       8'h02
`define MANT_125US          8'h7D
`define EXP_125US           8'hFA
`define MANT_250US          8'h19
`define EXP_250US           8'hFB
`define MANT_500US          8'h05
`define EXP_500US           8'hFC
`define MANT_1MS            8'h01
`define MANT_2MS            8'h02
`define MANT_4MS            8'h04
`define MANT_8MS            8'h08
`define EXP_MS              8'hFD
`define MANT_10MS           8'h0A
`define EXP_10MS            8'hFE
`define CYC_125US           3'h0
`define CYC_250US           3'h1
`define CYC_500US           3'h2
`define CYC_1MS             3'h3
`define CYC_2MS             3'h4
`define CYC_4MS             3'h5
`define CYC_8MS             3'h6
`define CYC_10MS            3'h7
`define MT_CLEAR_MIN_LEVEL  4'h3
`define CTRL_MT_CLEAR_BIT   0
`define CTRL_FULL_CLOSED    1
`define CTRL_ROTARY         2
`define CTRL_POS_MODE       3
`endif

// ---- logic/interp_sync3.v ----
// three-stage input synchroniser with agreement check
module interp_sync3 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         ce_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end else if (ce_i) begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_o <= s3_q;
            end
        end
    end
endmodule // interp_sync3

// ---- verification/fieldbus_master_model.sv ----
// fieldbus master model on the register port
module fieldbus_master_model (
    input  logic        clk_i,
    input  logic [31:0] rdata_i,
    output logic [3:0]  addr_o = 4'h0,
    output logic [31:0] wdata_o = 32'h0,
    output logic        wr_o = 1'b0,
    output logic        rd_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask
    // period fields left alone; jerk settings zeroed before jerk use
    task automatic jerk_setup;
        wr(4'hA, 32'h0);
        wr(4'hB, 32'h0);
        wr(4'hC, 32'h0);
        wr(4'hD, 32'h1);
    endtask
endmodule // fieldbus_master_model

// ---- verification/interp_period_config_test.sv ----
// self-checking bench for the interpolation period block
module interp_period_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, ce = 1, cload = 0, dirc = 0, wr, rd, mtc, act;
    logic [2:0]  csel = 3'h0;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, raw = 32'h0, fb, d, amt;
    logic [7:0]  mant, expo;
    int          mismatches = 0, n_compared = 0;
    logic [7:0]  mt [8] = '{8'h7D, 8'h19, 8'h05, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0A};
    logic [7:0]  et [8] = '{8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFD, 8'hFD, 8'hFD, 8'hFE};
    always #2 clk = ~clk;
    fieldbus_master_model u_fieldbus_master_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    interp_period_config u_interp_period_config (.CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .CYCLE_SEL_I(csel), .CYCLE_LOAD_I(cload), .RAW_POS_I(raw), .DIR_CHANGE_I(dirc),
        .FEEDBACK_POS_O(fb), .MT_CLEAR_O(mtc), .LASH_ACTIVE_O(act), .PERIOD_MANT_O(mant),
        .PERIOD_EXP_O(expo));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] sx(input logic [7:0] v);
        return {{24{v[7]}}, v};
    endfunction
    task automatic finish_test;
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        finish_test;
    end
    initial begin
        void'($urandom(32'hd00d9f2e));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        u_fieldbus_master_model.rd(4'h0, d);
        chk(d, 32'h2);
        u_fieldbus_master_model.wr(4'h0, 32'h5);
        u_fieldbus_master_model.rd(4'h0, d);
        chk(d, 32'h2);
        for (int c = 7; c >= 0; c--) begin
            @(posedge clk);
            csel <= c[2:0];
            cload <= 1'b1;
            repeat (6) @(posedge clk);
            cload <= 1'b0;
            repeat (8) @(posedge clk);
            u_fieldbus_master_model.rd(4'h1, d);
            chk(d, {24'h0, mt[c]});
            u_fieldbus_master_model.rd(4'h2, d);
            chk(d, sx(et[c]));
        end
        repeat (4) begin
            amt = $urandom;
            u_fieldbus_master_model.wr(4'h1, {24'h0, amt[7:0]});
            u_fieldbus_master_model.wr(4'h2, {24'h0, amt[15:8]});
            u_fieldbus_master_model.rd(4'h2, d);
            chk(d, sx(amt[15:8]));
            chk({24'h0, mant}, {24'h0, amt[7:0]});
            chk({24'h0, expo}, {24'h0, amt[15:8]});
        end
        // a write while the enable is low must leave the mantissa alone
        @(posedge clk);
        ce <= 1'b0;
        u_fieldbus_master_model.wr(4'h1, {24'h0, ~amt[7:0]});
        ce <= 1'b1;
        u_fieldbus_master_model.rd(4'h1, d);
        chk(d, {24'h0, amt[7:0]});
        u_fieldbus_master_model.wr(4'h7, 32'h3);
        @(negedge clk);
        chk({31'h0, mtc}, 32'h0);
        u_fieldbus_master_model.rd(4'h8, d);
        chk({31'h0, d[2]}, 32'h1);
        u_fieldbus_master_model.wr(4'h7, 32'h7);
        @(negedge clk);
        chk({31'h0, mtc}, 32'h1);
        u_fieldbus_master_model.rd(4'h8, d);
        chk({29'h0, d[2:0]}, 32'h1);
        @(posedge clk);
        amt = $urandom;
        raw <= $urandom;
        u_fieldbus_master_model.wr(4'h4, 32'h1);
        u_fieldbus_master_model.wr(4'h5, {16'h0, amt[15:0]});
        u_fieldbus_master_model.wr(4'h6, 32'h4);
        u_fieldbus_master_model.wr(4'h7, 32'hA);
        dirc <= 1'b1;
        repeat (2) @(posedge clk);
        dirc <= 1'b0;
        for (int i = 0; i < 20 && act !== 1'b1; i++) @(negedge clk);
        chk(fb, raw + {{16{amt[15]}}, amt[15:0]});
        for (int i = 0; i < 30 && act !== 1'b0; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk(fb, raw);
        u_fieldbus_master_model.jerk_setup();
        u_fieldbus_master_model.rd(4'h8, d);
        chk({31'h0, d[3]}, 32'h1);
        finish_test;
    end
endmodule // interp_period_config_test

// ---- verification/interp_period_monitor.sv ----
// port assertions for the interpolation period block
module interp_period_monitor #(
    parameter POS_W = 32
) (
    input logic             CLOCK_I,
    input logic             SYS_RST_I,
    input logic             CE_I,
    input logic [3:0]       ADDR_I,
    input logic [31:0]      WDATA_I,
    input logic             WR_I,
    input logic             RD_I,
    input logic [31:0]      RDATA_O,
    input logic [POS_W-1:0] RAW_POS_I,
    input logic [POS_W-1:0] FEEDBACK_POS_O,
    input logic             MT_CLEAR_O,
    input logic             LASH_ACTIVE_O,
    input logic [7:0]       PERIOD_MANT_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    wire ctl_wr = CE_I && WR_I && ADDR_I == 4'h7;
    wire clr_wr = ctl_wr && WDATA_I[0];
    // an enable high two edges back, with no transition, passes the raw position to the feedback
    property p_fb_plain;
        !LASH_ACTIVE_O [*3] ##0 $past(CE_I, 2)
            |-> $past(FEEDBACK_POS_O) == $past(RAW_POS_I, 2);
    endproperty
    property p_mant;
        logic [7:0] v;
        (CE_I && WR_I && ADDR_I == 4'h1, v = WDATA_I[7:0]) |-> ##2 PERIOD_MANT_O == v;
    endproperty
    a_highest_fixed: assert property (CE_I && RD_I && ADDR_I == 4'h0 |=> RDATA_O == 32'h2)
        else $error("highest entry not 2");
    a_mant_write: assert property (p_mant)
        else $error("mantissa not written");
    a_exp_signed: assert property (CE_I && RD_I && ADDR_I == 4'h2 |=> RDATA_O[31:8] == {24{RDATA_O[7]}})
        else $error("exponent not sign extended");
    a_clear_accept: assert property (ctl_wr && WDATA_I[2:0] == 3'h7 |=> MT_CLEAR_O)
        else $error("clear not accepted");
    a_clear_refuse: assert property (ctl_wr && WDATA_I[2:1] != 2'h3 |=> !MT_CLEAR_O)
        else $error("clear not refused");
    a_clear_pulse: assert property (MT_CLEAR_O && CE_I && !clr_wr |=> !MT_CLEAR_O)
        else $error("clear pulse too long");
    a_fb_plain: assert property (p_fb_plain)
        else $error("feedback carries correction");
    c_clear: cover property (MT_CLEAR_O);
    c_lash: cover property ($rose(LASH_ACTIVE_O));
    c_exp: cover property (RD_I && ADDR_I == 4'h2);
endmodule // interp_period_monitor

bind interp_period_config interp_period_monitor #(.POS_W(POS_W)) u_mon (.CLOCK_I(CLOCK_I),
    .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .RAW_POS_I(RAW_POS_I), .FEEDBACK_POS_O(FEEDBACK_POS_O),
    .MT_CLEAR_O(MT_CLEAR_O), .LASH_ACTIVE_O(LASH_ACTIVE_O), .PERIOD_MANT_O(PERIOD_MANT_O));
